/* rtl/rct_pkg.sv */
package rct_pkg;

  // register byte addresses on the avalon bus
  localparam logic [3:0] RCT_ADDR_CAUSE = 4'h0;
  localparam logic [3:0] RCT_ADDR_BKUP = 4'h4;
  localparam logic [3:0] RCT_ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] RCT_ADDR_IRQ_MASK = 4'hC;

  // reset-cause field positions
  localparam int RCT_B_POR = 0;
  localparam int RCT_B_BOR = 1;
  localparam int RCT_B_IDLE = 2;
  localparam int RCT_B_SLEEP = 3;
  localparam int RCT_B_WATCHDOG_TIMEOUT_FLAG = 4;
  localparam int RCT_B_SWDT = 5;
  localparam int RCT_B_INSTR = 6;
  localparam int RCT_B_PIN = 7;
  localparam int RCT_B_FBIAS = 8;
  localparam int RCT_B_CM = 9;
  localparam int RCT_B_DSLP = 10;
  localparam int RCT_B_RETENTION_ENABLE = 12;
  localparam int RCT_B_ILL = 14;
  localparam int RCT_B_TRAP = 15;

  // writable mask and power-on value of the reset-cause register
  localparam logic [15:0] RCT_CAUSE_WMASK = 16'hD7FF;
  localparam logic [15:0] RCT_CAUSE_POR = 16'h0003;

  // backup-power register fields
  localparam int RCT_B_VBAT = 0;
  localparam int RCT_B_BATTERY_POWER_ON_FLAG = 1;
  localparam int RCT_B_SUPPLY_POWER_ON_FLAG = 2;
  localparam int RCT_B_SUPPLY_BROWNOUT_FLAG = 3;
  localparam logic [3:0] RCT_BKUP_POR = 4'hE;

  // interrupt event bits: one per reset source seen
  localparam int RCT_NEV = 9;
  localparam logic [8:0] RCT_IRQ_MASK_RST = 9'h000;

  // reset source bundle
  typedef struct packed {
    logic por;
    logic pin;
    logic instr;
    logic wdt;
    logic bor;
    logic cm;
    logic trap;
    logic illop;
    logic uninitialized_register_reset;
  } rct_src_t;

  // processor events and supply monitors
  typedef struct packed {
    logic pwrsav0;
    logic pwrsav1;
    logic wdt_clr;
    logic deep_sleep_enable;
    logic vdd_por;
    logic vdd_bor;
    logic on_battery;
  } rct_evt_t;

endpackage

/* rtl/rct_reset_cause.sv */
// The Avalon-MM register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
// Function
// - any active reset source drives the master system reset
// - nine sources: por, pin, instr, wdt, bor, cm, trap, illop, uwr
// - each reset sets a cause flag, uwr sharing the illop flag; battery resets set the VBAT backup flag
// - power-on clears cause register except brown-out and power-on set
// - software may set or clear flags; writes never cause a reset
// - trap, illegal-opcode, mismatch flags set by events, cleared by por
// - deep-sleep flag set on sleep with deep-sleep enable, cleared by por
// - watchdog flag set on timeout, cleared by clear, power-save, por
// - sleep flag set on power-save zero, cleared only by por or a software write
// - idle flag set on power-save one, cleared only by por or a software write
// - brown-out flag set on brown-out and power-on reset
// - power-on flag bit zero set on core power-on reset
// - bit five enables watchdog; unprogrammed fuse forces it on
// - retention bit enables regulator only when low-power fuse programmed
// - backup flags set by hardware only, software only clears
// - battery power-on flag set at initial power-up regardless of battery
// - main supply por in backup register, core por in bit zero
module rct_reset_cause (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // reset sources, asynchronous levels
  input wire rct_pkg::rct_src_t i_src,
  // processor events and supply monitors
  input wire rct_pkg::rct_evt_t i_evt,
  // configuration fuses, one means unprogrammed
  input wire logic i_watchdog_config_fuse,
  input wire logic i_low_power_regulator_fuse,
  // avalon-mm slave
  input wire logic [3:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [3:0] i_byteenable,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  // outputs
  output logic o_master_system_reset,
  output logic o_watchdog_enable,
  output logic o_retention_regulator_on,
  output logic o_flash_bias_in_sleep,
  output logic o_irq
);
  import rct_pkg::*;

  logic [8:0] src_m_q, src_s_q, src_prev_q;
  logic [6:0] evt_m_q, evt_s_q;
  logic [15:0] cause_q;
  logic [3:0] bkup_q;
  logic [8:0] ist_q, imask_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic init_q;
  logic mrst_q;
  rct_src_t src;
  rct_evt_t evt;
  logic [8:0] src_rise;
  logic wr_acc, rd_acc;
  logic [31:0] wmask;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic reg_hit(input logic acc, input logic [3:0] a,
                                   input logic [3:0] r);
    reg_hit = acc && (a == r);
  endfunction

  // pins are asynchronous to i_clk, two flops before use
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      src_m_q <= 9'h000;
      src_s_q <= 9'h000;
      evt_m_q <= 7'h00;
      evt_s_q <= 7'h00;
    end else begin
      src_m_q <= i_src;
      src_s_q <= src_m_q;
      evt_m_q <= i_evt;
      evt_s_q <= evt_m_q;
    end
  end

  assign src = rct_src_t'(src_s_q);
  assign evt = rct_evt_t'(evt_s_q);

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      src_prev_q <= 9'h000;
    end else begin
      src_prev_q <= src_s_q;
    end
  end
  assign src_rise = src_s_q & ~src_prev_q;

  // master reset: registered or of every source
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      mrst_q <= 1'b1;
    end else begin
      mrst_q <= |src_s_q;
    end
  end
  assign o_master_system_reset = mrst_q;

  // bus: one wait cycle then ack, so answer comes on the second edge
  assign wr_acc = i_write & ack_q;
  assign rd_acc = i_read & ack_q;
  assign wmask = lane_mask(i_byteenable);
  assign o_waitrequest = (i_read | i_write) & ~ack_q;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (i_read | i_write) & ~ack_q;
    end
  end

  // init_q marks the first cycle after reset release as initial power-up
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end

  // reset-cause register; a write only stores, it never feeds mrst_q
  always_ff @(posedge i_clk) begin
    logic [15:0] c;
    logic [15:0] m;
    c = cause_q;
    m = 16'h0000;
    if (!i_nrst) begin
      cause_q <= RCT_CAUSE_POR;
    end else begin
      m = wmask[15:0] & RCT_CAUSE_WMASK;
      if (reg_hit(wr_acc, i_address, RCT_ADDR_CAUSE)) begin
        c = (c & ~m) | (i_writedata[15:0] & m);
      end
      if (evt.wdt_clr || evt.pwrsav0 || evt.pwrsav1) begin
        c[RCT_B_WATCHDOG_TIMEOUT_FLAG] = 1'b0;
      end
      // hardware sets applied last so they win over a same-cycle clear
      if (src.por) begin
        c = RCT_CAUSE_POR;
      end else begin
        if (src_rise[0]) c[RCT_B_ILL] = 1'b1;
        if (src.illop) c[RCT_B_ILL] = 1'b1;
        if (src.trap) c[RCT_B_TRAP] = 1'b1;
        if (src.cm) c[RCT_B_CM] = 1'b1;
        if (src.bor) c[RCT_B_BOR] = 1'b1;
        if (src.pin) c[RCT_B_PIN] = 1'b1;
        if (src.instr) c[RCT_B_INSTR] = 1'b1;
        if (src.wdt) c[RCT_B_WATCHDOG_TIMEOUT_FLAG] = 1'b1;
        if (evt.pwrsav0) c[RCT_B_SLEEP] = 1'b1;
        if (evt.pwrsav1) c[RCT_B_IDLE] = 1'b1;
        if (evt.pwrsav0 && evt.deep_sleep_enable) begin
          c[RCT_B_DSLP] = 1'b1;
        end
      end
      cause_q <= c;
    end
  end

  // uninitialized register use shares the illegal-opcode flag
  // bit 0 of src_rise is the uwr field (last in the struct)

  assign o_watchdog_enable = i_watchdog_config_fuse |
    cause_q[RCT_B_SWDT];
  assign o_retention_regulator_on = ~i_low_power_regulator_fuse &
    cause_q[RCT_B_RETENTION_ENABLE];
  assign o_flash_bias_in_sleep = cause_q[RCT_B_FBIAS];

  // backup-power register: write-one-to-clear, hardware set only
  always_ff @(posedge i_clk) begin
    logic [3:0] b;
    b = bkup_q;
    if (!i_nrst) begin
      bkup_q <= RCT_BKUP_POR;
    end else begin
      if (reg_hit(wr_acc, i_address, RCT_ADDR_BKUP)) begin
        b = b & ~(i_writedata[3:0] & wmask[3:0]);
      end
      if (init_q) b[RCT_B_BATTERY_POWER_ON_FLAG] = 1'b1;
      if (evt.vdd_por) b[RCT_B_SUPPLY_POWER_ON_FLAG] = 1'b1;
      if (evt.vdd_bor) b[RCT_B_SUPPLY_BROWNOUT_FLAG] = 1'b1;
      if (evt.on_battery && |src_rise) b[RCT_B_VBAT] = 1'b1;
      bkup_q <= b;
    end
  end

  // interrupt status: one bit per new reset source, w1c, set wins
  always_ff @(posedge i_clk) begin
    logic [8:0] s;
    s = ist_q;
    if (!i_nrst) begin
      ist_q <= 9'h000;
    end else begin
      if (reg_hit(wr_acc, i_address, RCT_ADDR_IRQ_STAT)) begin
        s = s & ~(i_writedata[8:0] & wmask[8:0]);
      end
      s = s | src_rise;
      ist_q <= s;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      imask_q <= RCT_IRQ_MASK_RST;
    end else if (reg_hit(wr_acc, i_address, RCT_ADDR_IRQ_MASK)) begin
      imask_q <= (imask_q & ~wmask[8:0]) | (i_writedata[8:0] & wmask[8:0]);
    end
  end
  assign o_irq = |(ist_q & imask_q);

  // read data; unmapped addresses read zero
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rdata_q <= 32'h00000000;
    end else if (i_read && !ack_q) begin
      case (i_address)
        RCT_ADDR_CAUSE: rdata_q <= {16'h0000, cause_q};
        RCT_ADDR_BKUP: rdata_q <= {28'h0000000, bkup_q};
        RCT_ADDR_IRQ_STAT: rdata_q <= {23'h000000, ist_q};
        RCT_ADDR_IRQ_MASK: rdata_q <= {23'h000000, imask_q};
        default: rdata_q <= 32'h00000000;
      endcase
    end
  end
  assign o_readdata = rdata_q;

  // checks
  chk_src_to_reset: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    |src_s_q |=> o_master_system_reset)
    else $error("source active without master reset");
  chk_reset_release: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    !(|src_s_q) |=> !o_master_system_reset)
    else $error("master reset without source");
  chk_por_value: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    src.por |=> cause_q == RCT_CAUSE_POR)
    else $error("power-on value wrong");
  chk_trap_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    src.trap && !src.por |=> cause_q[RCT_B_TRAP])
    else $error("trap flag not set");
  chk_watchdog_timeout_flag_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    src.wdt && !src.por |=> cause_q[RCT_B_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog flag not set");
  chk_watchdog_timeout_flag_clr: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    evt.wdt_clr && !src.wdt && !src.por |=> !cause_q[RCT_B_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog flag not cleared");
  chk_dslp_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    evt.pwrsav0 && evt.deep_sleep_enable && !src.por
    |=> cause_q[RCT_B_DSLP] && cause_q[RCT_B_SLEEP])
    else $error("deep sleep flag not set");
  chk_idle_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    evt.pwrsav1 && !src.por |=> cause_q[RCT_B_IDLE])
    else $error("idle flag not set");
  chk_wdt_fuse: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    i_watchdog_config_fuse |-> o_watchdog_enable)
    else $error("watchdog off with fuse unprogrammed");
  chk_retention_enable_fuse: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    i_low_power_regulator_fuse |-> !o_retention_regulator_on)
    else $error("retention on with fuse unprogrammed");
  chk_bkup_hw_only: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    !evt.vdd_por |=> !$rose(bkup_q[RCT_B_SUPPLY_POWER_ON_FLAG]))
    else $error("backup flag set without hardware");
  chk_supply_power_on_flag_wins: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    evt.vdd_por |=> bkup_q[RCT_B_SUPPLY_POWER_ON_FLAG])
    else $error("hardware set lost to clear");
  chk_write_no_reset: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    wr_acc && !(|src_s_q) |=> !o_master_system_reset)
    else $error("register write caused reset");
  chk_cm_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    src.cm && !src.por |=> cause_q[RCT_B_CM])
    else $error("mismatch flag not set");
  chk_ill_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (src.illop || src_rise[0]) && !src.por |=> cause_q[RCT_B_ILL])
    else $error("illegal opcode flag not set");
  chk_pin_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    src.pin && !src.por |=> cause_q[RCT_B_PIN])
    else $error("pin reset flag not set");
  chk_bor_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    src.bor || src.por |=> cause_q[RCT_B_BOR])
    else $error("brown-out flag not set");
  chk_por_only: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    !src.por && !wr_acc |=> !$rose(cause_q[RCT_B_POR]))
    else $error("power-on flag set without power-on");
  chk_sleep_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    evt.pwrsav0 && !src.por |=> cause_q[RCT_B_SLEEP])
    else $error("sleep flag not set");
  chk_sleep_hold: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    cause_q[RCT_B_SLEEP] && !src.por && !wr_acc |=> cause_q[RCT_B_SLEEP])
    else $error("sleep flag lost");
  chk_idle_hold: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    cause_q[RCT_B_IDLE] && !src.por && !wr_acc |=> cause_q[RCT_B_IDLE])
    else $error("idle flag lost");
  chk_dslp_cause: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    !(evt.pwrsav0 && evt.deep_sleep_enable) && !wr_acc
    |=> !$rose(cause_q[RCT_B_DSLP]))
    else $error("deep sleep flag set without cause");
  chk_watchdog_timeout_flag_psave: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    (evt.pwrsav0 || evt.pwrsav1) && !src.wdt && !src.por
    |=> !cause_q[RCT_B_WATCHDOG_TIMEOUT_FLAG])
    else $error("watchdog flag kept over power save");
  chk_battery_power_on_flag_init: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    init_q |=> bkup_q[RCT_B_BATTERY_POWER_ON_FLAG])
    else $error("battery power-on flag not set");
  chk_supply_brownout_flag_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    evt.vdd_bor |=> bkup_q[RCT_B_SUPPLY_BROWNOUT_FLAG])
    else $error("supply brown-out flag not set");
  chk_vbat_set: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    evt.on_battery && |src_rise |=> bkup_q[RCT_B_VBAT])
    else $error("battery reset flag not set");
  chk_ist_set_wins: assert property (
    @(posedge i_clk) disable iff (!i_nrst)
    |src_rise |=> &(ist_q | ~$past(src_rise)))
    else $error("interrupt status set lost");

  cov_por: cover property (@(posedge i_clk) disable iff (!i_nrst) src.por);
  cov_wdt: cover property (@(posedge i_clk) disable iff (!i_nrst)
    src.wdt ##1 evt.wdt_clr);
  cov_irq: cover property (@(posedge i_clk) disable iff (!i_nrst) o_irq);
  cov_bus_rw: cover property (@(posedge i_clk) disable iff (!i_nrst)
    wr_acc ##[1:4] rd_acc);
  cov_deep_sleep: cover property (@(posedge i_clk) disable iff (!i_nrst)
    evt.pwrsav0 && evt.deep_sleep_enable);

endmodule

/* testbench/rct_src_model.sv */
`timescale 1ns/1ps
// reset sources and processor events seen by the tracker
module rct_src_model (
  // clock
  input wire logic i_clk,
  // pulse request: one-hot or grouped bits of {src, evt}
  input wire logic i_go,
  input wire logic [15:0] i_sel,
  // steady levels such as fuses-like enables and battery state
  input wire logic [15:0] i_lvl,
  // towards the tracker
  output rct_pkg::rct_src_t o_src,
  output rct_pkg::rct_evt_t o_evt
);
  import rct_pkg::*;
  logic [2:0] cnt_q = 3'h0;
  logic [15:0] sel_q = 16'h0000;
  // held four cycles so the two-flop synchroniser cannot miss it
  always @(posedge i_clk) begin
    if (i_go) begin
      cnt_q <= 3'h4;
      sel_q <= i_sel;
    end else if (cnt_q != 3'h0) begin
      cnt_q <= cnt_q - 3'h1;
    end
  end
  assign {o_src, o_evt} = i_lvl | ((cnt_q != 3'h0) ? sel_q : 16'h0000);
endmodule

/* testbench/tb_reset_cause_tracking.sv */
`timescale 1ns/1ps
module tb_reset_cause_tracking;
  import rct_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  rct_src_t src;
  rct_evt_t evt;
  logic wfuse = 1'b0;
  logic lfuse = 1'b0;
  logic [3:0] addr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic wreq, msr, wde, ret, fbias, irq;
  logic go = 1'b0;
  logic [15:0] sel = 16'h0000;
  logic [15:0] lvl = 16'h0000;
  logic [31:0] q;
  int bad_count = 0;
  int cmp_count = 0;
  always #2.5 clk = ~clk;
  rct_src_model model (.i_clk(clk), .i_go(go), .i_sel(sel), .i_lvl(lvl),
    .o_src(src), .o_evt(evt));
  rct_reset_cause uut (.i_clk(clk), .i_nrst(nrst), .i_src(src),
    .i_evt(evt), .i_watchdog_config_fuse(wfuse),
    .i_low_power_regulator_fuse(lfuse), .i_address(addr), .i_read(rd),
    .i_write(wr), .i_writedata(wdat), .i_byteenable(4'hF),
    .o_readdata(rdat), .o_waitrequest(wreq), .o_master_system_reset(msr),
    .o_watchdog_enable(wde), .o_retention_regulator_on(ret),
    .o_flash_bias_in_sleep(fbias), .o_irq(irq));
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkb(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask
  // request held until the rising edge that samples waitrequest low
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e,
                       input string n);
    bus(1'b0, a, 32'h0);
    chk(n, e, q);
  endtask
  task automatic pulse(input logic [15:0] s, input logic m);
    @(posedge clk);
    sel <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chkb("master_reset", m, msr);
    repeat (8) @(posedge clk);
    chkb("master_idle", 1'b0, msr);
  endtask
  task automatic t_reset;
    rdchk(RCT_ADDR_CAUSE, 32'h0003, "cause");
    rdchk(RCT_ADDR_BKUP, 32'h000E, "backup");
    rdchk(RCT_ADDR_IRQ_MASK, 32'h0, "irq_mask");
    rdchk(4'h2, 32'h0, "unmapped");
  endtask
  task automatic t_soft;
    bus(1'b1, RCT_ADDR_CAUSE, 32'hFFFF);
    rdchk(RCT_ADDR_CAUSE, {16'h0, RCT_CAUSE_WMASK}, "cause_all");
    chkb("master_sw", 1'b0, msr);
    chkb("wdt_en", 1'b1, wde);
    chkb("retention", 1'b1, ret);
    chkb("flash_bias", 1'b1, fbias);
    lfuse <= 1'b1;
    @(negedge clk);
    chkb("retention_fuse", 1'b0, ret);
    bus(1'b1, RCT_ADDR_CAUSE, 32'h0);
    @(negedge clk);
    chkb("wdt_off", 1'b0, wde);
    @(posedge clk);
    wfuse <= 1'b1;
    @(negedge clk);
    chkb("wdt_fuse", 1'b1, wde);
    @(posedge clk);
    wfuse <= 1'b0;
    lfuse <= 1'b0;
  endtask
  task automatic t_sources;
    int cb[9];
    cb = '{0, 7, 6, 4, 1, 9, 15, 14, 14};
    bus(1'b1, RCT_ADDR_IRQ_MASK, 32'h1FF);
    for (int k = 1; k < 9; k++) begin
      pulse(16'h8000 >> k, 1'b1);
      rdchk(RCT_ADDR_CAUSE, 32'h1 << cb[k], "cause_src");
      rdchk(RCT_ADDR_IRQ_STAT, 32'h100 >> k, "irq_stat");
      chkb("irq_on", 1'b1, irq);
      bus(1'b1, RCT_ADDR_IRQ_MASK, 32'h0);
      @(negedge clk);
      chkb("irq_masked", 1'b0, irq);
      bus(1'b1, RCT_ADDR_IRQ_MASK, 32'h1FF);
      bus(1'b1, RCT_ADDR_IRQ_STAT, 32'h1FF);
      bus(1'b1, RCT_ADDR_CAUSE, 32'h0);
      @(negedge clk);
      chkb("irq_clr", 1'b0, irq);
    end
  endtask
  task automatic t_por;
    bus(1'b1, RCT_ADDR_CAUSE, 32'hFFFF);
    pulse(16'h8000, 1'b1);
    rdchk(RCT_ADDR_CAUSE, 32'h0003, "cause_por");
    bus(1'b1, RCT_ADDR_IRQ_STAT, 32'h1FF);
  endtask
  task automatic t_power_save;
    bus(1'b1, RCT_ADDR_CAUSE, 32'h0);
    lvl <= 16'h0008;
    pulse(16'h0040, 1'b0);
    rdchk(RCT_ADDR_CAUSE, 32'h0408, "cause_sleep");
    lvl <= 16'h0000;
    bus(1'b1, RCT_ADDR_CAUSE, 32'h0018);
    pulse(16'h0010, 1'b0);
    rdchk(RCT_ADDR_CAUSE, 32'h0008, "cause_watchdog_clear_instruction");
    bus(1'b1, RCT_ADDR_CAUSE, 32'h0010);
    pulse(16'h0020, 1'b0);
    rdchk(RCT_ADDR_CAUSE, 32'h0004, "cause_idle");
  endtask
  task automatic t_backup;
    bus(1'b1, RCT_ADDR_BKUP, 32'hF);
    rdchk(RCT_ADDR_BKUP, 32'h0, "bkup_clr");
    pulse(16'h0006, 1'b0);
    rdchk(RCT_ADDR_BKUP, 32'hC, "bkup_vdd");
    lvl <= 16'h0001;
    pulse(16'h4000, 1'b1);
    rdchk(RCT_ADDR_BKUP, 32'hD, "bkup_vbat");
    lvl <= 16'h0004;
    bus(1'b1, RCT_ADDR_BKUP, 32'hF);
    rdchk(RCT_ADDR_BKUP, 32'h4, "bkup_set_wins");
    lvl <= 16'h0000;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_soft();
    t_sources();
    t_por();
    t_power_save();
    t_backup();
    stop_test();
  end
endmodule
